// [include/fdrs_pkg.sv]
/*
 * Package for the flash data row sequencer: register layout, reset values,
 * address base, timing counts, sequencer states and the core-side carriers.
 * Assumes a single 125 MHz clock and one core instruction per strobe.
 */
`default_nettype none

package fdrs_pkg;
    // ==========================================================
    // Register fields
    localparam int FDRS_BIT_READ    = 0;
    localparam int FDRS_BIT_START   = 1;
    localparam int FDRS_BIT_UNLOCK  = 2;
    localparam int FDRS_BIT_ERR     = 3;
    localparam int FDRS_BIT_ERASE   = 4;
    localparam int FDRS_ADDR_W      = 6;
    localparam int FDRS_ARR_ADDR_W  = 11;
    localparam int FDRS_ROW_W       = 3;
    localparam int FDRS_COL_W       = 3;
    localparam logic [7:0]  FDRS_CTRL_RST  = 8'h00;
    localparam logic [7:0]  FDRS_DATA_RST  = 8'h00;
    localparam logic [5:0]  FDRS_ADDR_RST  = 6'h00;
    localparam logic [10:0] FDRS_ARR_BASE  = 11'h400;
    localparam logic [7:0]  FDRS_ERASED    = 8'hff;
    localparam logic [7:0]  FDRS_CTRL_MASK = 8'h1f;

    // ==========================================================
    // Timing
    localparam int FDRS_CLK_MHZ     = 125;
    localparam int FDRS_PROG_US     = 2;
    localparam int FDRS_PROG_CYC    = FDRS_PROG_US * FDRS_CLK_MHZ;
    localparam int FDRS_CNT_W       = 16;

    // ==========================================================
    // Register select and write kind from the core
    typedef enum logic [1:0] {
        FDRS_SEL_NONE = 2'h0,
        FDRS_SEL_CTRL = 2'h1,
        FDRS_SEL_ADDR = 2'h2,
        FDRS_SEL_DATA = 2'h3
    } fdrs_sel_t;

    typedef struct packed {
        logic       wr;
        fdrs_sel_t  sel;
        logic       bit_set;
        logic [2:0] bit_idx;
        logic [7:0] wdata;
    } fdrs_req_t;

    typedef enum logic [1:0] {
        FDRS_IDLE  = 2'b00,
        FDRS_READ  = 2'b01,
        FDRS_PROG  = 2'b11,
        FDRS_CLEAR = 2'b10
    } fdrs_state_t;

    typedef struct packed {
        fdrs_state_t           st;
        logic                  erase;
        logic                  err;
        logic                  unlock;
        logic                  start;
        logic                  rd;
        logic                  erase_arm;
        logic                  unlock_arm;
        logic [5:0]            addr;
        logic [7:0]            data;
        logic [FDRS_CNT_W-1:0] cnt;
        logic [FDRS_COL_W-1:0] col;
        logic                  stall;
        logic                  mem_we;
        logic [5:0]            mem_addr;
        logic [7:0]            mem_wd;
    } fdrs_regs_t;
endpackage

`default_nettype wire

// [rtl/fdrs_mem.sv]
/*
 * 64 x 8 data array with a registered read port.
 * Assumes one write or one read per cycle from the sequencer.
 */
`default_nettype none

module fdrs_mem
    import fdrs_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       we,
    input  wire logic [5:0] addr,
    input  wire logic [7:0] wdata,
    output var  logic [7:0] rdata_ff
);
    // ==========================================================
    // Storage
    logic [7:0] mem [0:63];

    always_ff @(posedge sys_clk) begin
        if (we) begin
            mem[addr] <= wdata;
        end
        rdata_ff <= mem[addr];
    end
endmodule

`default_nettype wire

// [rtl/fdrs_top.sv]
/*
 * Flash data row sequencer: control, address and data registers, unlock
 * order, byte read, row erase, byte write, core stall and error flag.
 * Assumes the core presents one register access per instruction strobe
 * and holds off its next instruction while stall_ff is high.
 */
// How it works
// - Erase select makes program cycle erase row
// - Erase select clears after erase finishes
// - One-cycle reset during program sets error flag
// - Program cycles blocked while unlock is clear
// - Start begins cycle, reads zero when done
// - Read trigger fetches byte at address
// - Load address, trigger, data next cycle
// - Only single-bit-set starts a read
// - Erase order: select, unlock, start
// - Unlock missing on next instruction clears erase select
// - Start missing on next instruction clears unlock
// - Unlock and start need single-bit-set
// - Next instruction runs without padding
// - Core stalls during read, erase, write
// - Location is address plus base, bytes
`default_nettype none

module fdrs_top
    import fdrs_pkg::*;
#(
    parameter int PROG_CYC = FDRS_PROG_CYC
)(
    input  wire logic        sys_clk,
    input  wire logic        srst,
    input  wire logic        instr_stb,
    input  wire fdrs_req_t   req,
    output var  logic [7:0]  flash_control_reg_ff,
    output var  logic [5:0]  flash_address_reg_ff,
    output var  logic [7:0]  flash_data_reg_ff,
    output var  logic        stall_ff,
    output var  logic [10:0] array_loc_ff
);
    // ==========================================================
    // State
    fdrs_regs_t r_ff;
    fdrs_regs_t nxt_r;
    logic [7:0] mem_rd;
    logic       bset_ctrl;
    logic       wr_ctrl;

    localparam logic [FDRS_CNT_W-1:0] PROG_LAST = FDRS_CNT_W'(PROG_CYC - 1);

    // Array driven from the next state so read data is ready one cycle after the trigger
    fdrs_mem u_mem (
        .sys_clk  (sys_clk),
        .we       (nxt_r.mem_we && !srst),
        .addr     (nxt_r.mem_addr),
        .wdata    (nxt_r.mem_wd),
        .rdata_ff (mem_rd)
    );

    assign wr_ctrl   = instr_stb && req.wr && req.sel == FDRS_SEL_CTRL;
    assign bset_ctrl = wr_ctrl && req.bit_set;

    // ==========================================================
    // Next state
    always_comb begin
        nxt_r        = r_ff;
        nxt_r.mem_we = 1'b0;
        if (instr_stb) begin
            nxt_r.erase_arm  = 1'b0;
            nxt_r.unlock_arm = 1'b0;
        end
        unique case (r_ff.st)
            FDRS_IDLE: begin
                nxt_r.stall = 1'b0;
                // Lapsed unlock steps are dropped on the following instruction
                if (instr_stb && r_ff.erase_arm &&
                    !(bset_ctrl && req.bit_idx == 3'(FDRS_BIT_UNLOCK))) begin
                    nxt_r.erase = 1'b0;
                end
                if (instr_stb && r_ff.unlock_arm &&
                    !(bset_ctrl && req.bit_idx == 3'(FDRS_BIT_START))) begin
                    nxt_r.unlock = 1'b0;
                end
                if (instr_stb && req.wr && req.sel == FDRS_SEL_ADDR) begin
                    nxt_r.addr = req.wdata[5:0];
                end
                if (instr_stb && req.wr && req.sel == FDRS_SEL_DATA) begin
                    nxt_r.data = req.wdata;
                end
                if (wr_ctrl) begin
                    // Erase select by any write; error flag writable
                    if (req.bit_set) begin
                        if (req.bit_idx == 3'(FDRS_BIT_ERASE)) begin
                            nxt_r.erase     = 1'b1;
                            nxt_r.erase_arm = 1'b1;
                        end
                        if (req.bit_idx == 3'(FDRS_BIT_ERR)) begin
                            nxt_r.err = 1'b1;
                        end
                    end else begin
                        nxt_r.erase = req.wdata[FDRS_BIT_ERASE];
                        nxt_r.err   = req.wdata[FDRS_BIT_ERR];
                        nxt_r.erase_arm = req.wdata[FDRS_BIT_ERASE] && !r_ff.erase;
                    end
                end
                if (bset_ctrl && req.bit_idx == 3'(FDRS_BIT_UNLOCK)) begin
                    nxt_r.unlock     = 1'b1;
                    nxt_r.unlock_arm = 1'b1;
                    if (r_ff.erase_arm) begin
                        nxt_r.erase = 1'b1;
                    end
                end
                if (bset_ctrl && req.bit_idx == 3'(FDRS_BIT_START) &&
                    r_ff.unlock && r_ff.unlock_arm) begin
                    nxt_r.start = 1'b1;
                    nxt_r.stall = 1'b1;
                    nxt_r.cnt   = '0;
                    nxt_r.col   = '0;
                    nxt_r.st    = r_ff.erase ? FDRS_CLEAR : FDRS_PROG;
                end
                if (bset_ctrl && req.bit_idx == 3'(FDRS_BIT_READ)) begin
                    nxt_r.rd       = 1'b1;
                    nxt_r.stall    = 1'b1;
                    nxt_r.mem_addr = r_ff.addr;
                    nxt_r.st       = FDRS_READ;
                end
            end
            FDRS_READ: begin
                // Array read data registered one cycle after the address
                nxt_r.data  = mem_rd;
                nxt_r.rd    = 1'b0;
                nxt_r.stall = 1'b0;
                nxt_r.st    = FDRS_IDLE;
            end
            FDRS_PROG: begin
                nxt_r.mem_we   = r_ff.cnt == '0;
                nxt_r.mem_addr = r_ff.addr;
                nxt_r.mem_wd   = r_ff.data;
                nxt_r.cnt      = r_ff.cnt + 1'b1;
                if (r_ff.cnt == PROG_LAST) begin
                    nxt_r.start  = 1'b0;
                    nxt_r.unlock = 1'b0;
                    nxt_r.err    = 1'b0;
                    nxt_r.stall  = 1'b0;
                    nxt_r.st     = FDRS_IDLE;
                end
            end
            FDRS_CLEAR: begin
                // Whole row of eight bytes set to the erased value, no data write
                nxt_r.mem_we   = r_ff.cnt < FDRS_CNT_W'(8);
                nxt_r.mem_addr = {r_ff.addr[5:3], r_ff.col};
                nxt_r.mem_wd   = FDRS_ERASED;
                nxt_r.col      = r_ff.col + 1'b1;
                nxt_r.cnt      = r_ff.cnt + 1'b1;
                if (r_ff.cnt == PROG_LAST) begin
                    nxt_r.start  = 1'b0;
                    nxt_r.erase  = 1'b0;
                    nxt_r.unlock = 1'b0;
                    nxt_r.err    = 1'b0;
                    nxt_r.stall  = 1'b0;
                    nxt_r.st     = FDRS_IDLE;
                end
            end
        endcase
    end

    // ==========================================================
    // Registers
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            r_ff      <= '0;
            r_ff.err  <= r_ff.start;
            r_ff.addr <= FDRS_ADDR_RST;
            r_ff.data <= FDRS_DATA_RST;
        end else begin
            r_ff <= nxt_r;
        end
    end

    // ==========================================================
    // Outputs
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            flash_control_reg_ff <= FDRS_CTRL_RST;
            flash_address_reg_ff <= FDRS_ADDR_RST;
            flash_data_reg_ff    <= FDRS_DATA_RST;
            stall_ff             <= 1'b0;
            array_loc_ff         <= FDRS_ARR_BASE;
        end else begin
            flash_control_reg_ff <= {3'h0, nxt_r.erase, nxt_r.err, nxt_r.unlock,
                                     nxt_r.start, nxt_r.rd};
            flash_address_reg_ff <= nxt_r.addr;
            flash_data_reg_ff    <= nxt_r.data;
            stall_ff             <= nxt_r.stall;
            array_loc_ff         <= FDRS_ARR_BASE + {5'h00, nxt_r.addr};
        end
    end

    // ==========================================================
    // Checks
    sequence s_unlock_step;
        bset_ctrl && req.bit_idx == 3'(FDRS_BIT_UNLOCK) && r_ff.st == FDRS_IDLE;
    endsequence

    sequence s_start_step;
        bset_ctrl && req.bit_idx == 3'(FDRS_BIT_START) && r_ff.st == FDRS_IDLE;
    endsequence

    a_start_blocked: assert property (@(posedge sys_clk) disable iff (srst)
        s_start_step and !r_ff.unlock |=> r_ff.st == FDRS_IDLE)
        else $error("program started while unlock clear");

    a_unlock_start: assert property (@(posedge sys_clk) disable iff (srst)
        s_unlock_step ##1 s_start_step |=> r_ff.start && stall_ff)
        else $error("unlocked start did not begin a cycle");

    a_unlock_lapse: assert property (@(posedge sys_clk) disable iff (srst)
        r_ff.unlock_arm && instr_stb && !bset_ctrl && r_ff.st == FDRS_IDLE
        |=> !r_ff.unlock)
        else $error("unlock not cleared after lapse");

    a_erase_lapse: assert property (@(posedge sys_clk) disable iff (srst)
        r_ff.erase_arm && instr_stb && !bset_ctrl && r_ff.st == FDRS_IDLE
        |=> !r_ff.erase)
        else $error("erase select not cleared after lapse");

    a_read_data: assert property (@(posedge sys_clk) disable iff (srst)
        r_ff.st == FDRS_READ |=> r_ff.data == $past(mem_rd) && !r_ff.stall)
        else $error("read data not loaded next cycle");

    a_read_bset: assert property (@(posedge sys_clk) disable iff (srst)
        wr_ctrl && !req.bit_set && r_ff.st == FDRS_IDLE |=> r_ff.st != FDRS_READ)
        else $error("read started by non bit set write");

    a_erase_done: assert property (@(posedge sys_clk) disable iff (srst)
        r_ff.st == FDRS_CLEAR && r_ff.cnt == PROG_LAST |=> !r_ff.erase && !r_ff.start)
        else $error("erase select or start not cleared");

    a_stall_prog: assert property (@(posedge sys_clk) disable iff (srst)
        r_ff.st == FDRS_PROG |-> r_ff.stall && r_ff.start)
        else $error("core not stalled during write");
endmodule

`default_nettype wire

// [sim/fdrs_core_model.sv]
/*
 * Core-side model: issues one register instruction per strobe.
 * Assumes the sequencer samples on sys_clk and holds requests off while stalled.
 */
`default_nettype none

module fdrs_core_model
    import fdrs_pkg::*;
(
    input  wire logic      sys_clk,
    input  wire logic      stall_ff,
    output var  logic      instr_stb,
    output var  fdrs_req_t req
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // Instruction driver
    initial begin
        instr_stb = 1'b0;
        req       = '0;
    end

    // Hold the instruction until an edge where the core is not stalled
    task automatic issue(input fdrs_req_t r);
        instr_stb <= 1'b1;
        req       <= r;
        @(posedge sys_clk);
        while (stall_ff) @(posedge sys_clk);
    endtask

    // Released bus shows no stale value
    task automatic idle();
        instr_stb <= 1'b0;
        req       <= ~req;
    endtask
endmodule

`default_nettype wire

// [sim/tb_top.sv]
/*
 * Self-checking bench for the flash data row sequencer.
 * Assumes the core model in fdrs_core_model and a short program time.
 */
`default_nettype none

module tb_top
    import fdrs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int PC = 16;
    logic        sys_clk;
    logic        srst;
    logic        instr_stb;
    fdrs_req_t   req;
    logic [7:0]  ctrl;
    logic [5:0]  addr;
    logic [7:0]  data;
    logic        stall;
    logic [10:0] loc;
    int          n_errors;
    int          n_compared;

    // ==========================================================
    // Clock, design and core
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    fdrs_top #(.PROG_CYC(PC)) u_dut (
        .sys_clk(sys_clk), .srst(srst), .instr_stb(instr_stb), .req(req),
        .flash_control_reg_ff(ctrl), .flash_address_reg_ff(addr),
        .flash_data_reg_ff(data), .stall_ff(stall), .array_loc_ff(loc));
    fdrs_core_model core (
        .sys_clk(sys_clk), .stall_ff(stall), .instr_stb(instr_stb), .req(req));

    // ==========================================================
    // Shared tasks
    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask
    task automatic bset(input logic [2:0] idx);
        core.issue(fdrs_req_t'{1'b1, FDRS_SEL_CTRL, 1'b1, idx, ctrl | (8'h01 << idx)});
    endtask
    task automatic wreg(input fdrs_sel_t s, input logic [7:0] d);
        core.issue(fdrs_req_t'{1'b1, s, 1'b0, 3'h0, d});
    endtask
    task automatic wait_done(input int exp);
        int n;
        n = 0;
        core.idle();
        @(posedge sys_clk);
        while (stall && n < 1000) begin
            n++;
            @(posedge sys_clk);
        end
        check(16'(n), 16'(exp), "stall length");
    endtask
    task automatic read_byte(input logic [7:0] a, input logic [7:0] exp);
        wreg(FDRS_SEL_ADDR, a);
        bset(3'(FDRS_BIT_READ));
        wait_done(1);
        check(16'(data), 16'(exp), "read data");
        check(16'(loc), 16'(a[5:0]) + 16'(FDRS_ARR_BASE), "array loc");
        check(16'(addr), 16'(a[5:0]), "address reg");
        check(16'(ctrl[FDRS_BIT_READ]), 16'h0000, "read bit");
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_reset();
        srst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        srst <= 1'b0;
        @(posedge sys_clk);
        check(16'(ctrl), 16'(FDRS_CTRL_RST), "reset ctrl");
        check(16'(stall), 16'h0000, "reset stall");
        check(16'(loc), 16'(FDRS_ARR_BASE), "reset loc");
        $display("test reset done");
    endtask
    task automatic t_erase_write();
        wreg(FDRS_SEL_DATA, 8'ha5);
        wreg(FDRS_SEL_ADDR, 8'h05);
        bset(3'(FDRS_BIT_ERASE));
        bset(3'(FDRS_BIT_UNLOCK));
        bset(3'(FDRS_BIT_START));
        wait_done(PC);
        check(16'(ctrl), 16'h0000, "ctrl after erase");
        read_byte(8'h05, FDRS_ERASED);
        read_byte(8'h02, FDRS_ERASED);
        wreg(FDRS_SEL_ADDR, 8'h05);
        wreg(FDRS_SEL_DATA, 8'h3c);
        bset(3'(FDRS_BIT_UNLOCK));
        bset(3'(FDRS_BIT_START));
        read_byte(8'h07, FDRS_ERASED);
        check(16'(ctrl), 16'h0000, "ctrl after write");
        read_byte(8'h05, 8'h3c);
        $display("test erase write done");
    endtask
    task automatic t_lapse();
        bset(3'(FDRS_BIT_ERASE));
        wreg(FDRS_SEL_ADDR, 8'h05);
        core.idle();
        repeat (2) @(posedge sys_clk);
        check(16'(ctrl[FDRS_BIT_ERASE]), 16'h0000, "erase lapse");
        bset(3'(FDRS_BIT_UNLOCK));
        wreg(FDRS_SEL_DATA, 8'h55);
        core.idle();
        repeat (2) @(posedge sys_clk);
        check(16'(ctrl[FDRS_BIT_UNLOCK]), 16'h0000, "unlock lapse");
        bset(3'(FDRS_BIT_START));
        core.idle();
        repeat (3) @(posedge sys_clk);
        check(16'(stall), 16'h0000, "start locked");
        wreg(FDRS_SEL_CTRL, 8'h07);
        core.idle();
        repeat (3) @(posedge sys_clk);
        check(16'(stall), 16'h0000, "full write stall");
        check(16'(ctrl[2:0]), 16'h0000, "full write bits");
        check(16'(data), 16'h0055, "no read by write");
        wreg(FDRS_SEL_CTRL, 8'h10);
        core.idle();
        repeat (2) @(posedge sys_clk);
        check(16'(ctrl[FDRS_BIT_ERASE]), 16'h0001, "erase by full write");
        read_byte(8'h05, 8'h3c);
        $display("test lapse done");
    endtask
    task automatic t_abort();
        wreg(FDRS_SEL_DATA, 8'h11);
        bset(3'(FDRS_BIT_UNLOCK));
        bset(3'(FDRS_BIT_START));
        core.idle();
        repeat (4) @(posedge sys_clk);
        srst <= 1'b1;
        @(posedge sys_clk);
        srst <= 1'b0;
        repeat (2) @(posedge sys_clk);
        check(16'(ctrl), 16'h0008, "abort ctrl");
        check(16'(stall), 16'h0000, "abort stall");
        $display("test abort done");
    endtask

    // ==========================================================
    // Sequence, watchdog and verdict
    task automatic print_verdict();
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        n_errors = 0;
        n_compared = 0;
        srst = 1'b1;
        t_reset();
        t_erase_write();
        t_lapse();
        t_abort();
        print_verdict();
    end
    initial begin
        repeat (5000) @(posedge sys_clk);
        n_errors++;
        $display("ERROR %0t watchdog expired", $time);
        print_verdict();
    end
endmodule

`default_nettype wire
